/* cfg_pkg.sv */
// Purpose: Types shared by the reset strap configuration latch
// Assumes: Active-low straps, electrical levels as seen at the pins
// Notes: Field order of pin_bundle_type fixes the synchroniser layout
`default_nettype none

package cfg_pkg;

    // Raw pin levels, all passed through one synchroniser
    typedef struct packed {
        logic sys_reset_n;
        logic cache_flush_n;
        logic soft_init_n;
        logic strap_frc;
        logic strap_low_vector;
        logic strap_ioq_shallow;
        logic strap_addr_err_obs;
        logic strap_bus_err_obs;
        logic strap_bus_init_obs;
        logic strap_cluster_hi;
        logic strap_cluster_lo;
        logic [2:0] peer_pins; // Bit 2 is peer pin 3, bit 0 is peer pin 1
        logic addr_bit20_mask_n;
        logic ignore_fpu_err_n;
        logic [1:0] local_irq_pins;
    } pin_bundle_type;

    // Software-programmable policy bits
    typedef struct packed {
        logic standby_clock_gate_bit;
        logic bus_err_n_tgt_drive_en;
        logic bus_init_n_drive_en;
        logic bus_err_n_internal_drive_en;
        logic bus_err_n_init_drive_en;
        logic addr_err_drive_en;
        logic resp_par_chk_en;
        logic data_err_chk_en;
    } policy_type;

    // Hardware configuration captured at reset release
    typedef struct packed {
        logic outputs_float;
        logic addr_err_obs_en;
        logic bus_err_obs_en;
        logic bus_init_obs_en;
        logic [3:0] ioq_depth;
        logic [31:0] reset_vector;
        logic lockstep_en;
        logic lockstep_checker;
        logic [1:0] cluster_id;
        logic [1:0] agent_id;
        logic [1:0] arb_id;
        logic [3:0] ratio_raw; // local_irq_pins[1:0], ignore_fpu_err_n, addr_bit20_mask_n
    } hw_cfg_type;

    typedef enum logic [1:0] {
        ST_POWERUP,
        ST_HELD,
        ST_RUN
    } cfg_state_type;

endpackage : cfg_pkg

`default_nettype wire

/* pin_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of asynchronous pins
// Assumes: Single clock, synchronous active-low reset
// Notes: Only the second stage may be read by other logic
`include "strap_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pins_async,
    output logic [WIDTH-1:0] pins_sync
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("pin_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_type;

    sync_state_type q_r;
    sync_state_type q_nxt;

    // Shift one stage per clock; meta feeds only stable
    always_comb
    begin
        q_nxt = q_r;
        q_nxt.meta = pins_async;
        q_nxt.stable = q_r.meta;
    end

    // Idle to inactive-high so no false release is seen
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            q_r <= {(2 * WIDTH){`PIN_SYNC_RESET}};
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign pins_sync = q_r.stable;

endmodule : pin_sync

`default_nettype wire

/* reset_strap_config_latch.sv */
// Purpose: Latch hardware straps at system reset release and hold software policy bits
// Assumes: Straps and system reset arrive asynchronously on pins; policy writes are
//          single-cycle strobes from logic on core_clk
// Notes: Core clock ratio is kept as raw pin levels; its decode lives elsewhere
`include "strap_cfg_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) Flush strap low at release floats all outputs until a clean release.
// (R2) Soft init strap low at release starts built-in self test; no software path.
// (R3) Every reset clears data bus error checking; software may enable later.
// (R4) Every reset clears response parity checking; software may enable later.
// (R5) Every reset clears address parity error driving; software may enable later.
// (R6) Address error receiver enabled only by its strap low at release.
// (R7) Every reset disables bus error driving for initiator bus errors.
// (R8) Target-error drive bit resets off, is writable, never drives; errors still observed.
// (R9) Every reset disables bus error driving on internal errors.
// (R10) Bus error receiver strap option is not supported; receiver stays off.
// (R11) Every reset disables bus init driving; software normally enables it.
// (R12) Bus init receiver enabled only by its strap low at release.
// (R13) Queue depth one if shallow strap low at reset, else eight; fixed.
// (R14) Reset vector is 1M-16 with low-vector strap low, else 4G-16.
// (R15) Lockstep checking enabled when its strap is low at release.
// (R16) Cluster ID from hi/lo strap levels: HH 0, HL 1, LH 2, LL 3.
// (R17) System logic asserts request line 0 only at release; agents sample peers.
// (R18) Without lockstep, agent ID from the low peer pin; arbitration ID equals it.
// (R19) With lockstep, agents 1 and 3 check 0 and 2 and borrow their IDs.
// (R20) System gives each logical processor on the bus a distinct agent ID.
// (R21) Standby clock gate bit defaults 0 (clock runs); 1 gates core clock in standby.
// (R22) Ratio pins sampled from reset assertion and latched at its release.
// (R23) System holds straps from four clocks before to two clocks after release.
// (R24) Captured configuration stays fixed until next reset; all resets alike.
// (R25) Latched straps and policy bits are visible as status outputs.
module reset_strap_config_latch
    import cfg_pkg::*;
#(
    parameter int unsigned IOQ_DEEP = `IOQ_DEPTH_DEEP,
    parameter int unsigned IOQ_SHALLOW = `IOQ_DEPTH_SHALLOW
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic sys_reset_n,
    input wire logic cache_flush_n,
    input wire logic soft_init_n,
    input wire logic strap_frc,
    input wire logic strap_low_vector,
    input wire logic strap_ioq_shallow,
    input wire logic strap_addr_err_obs,
    input wire logic strap_bus_err_obs,
    input wire logic strap_bus_init_obs,
    input wire logic strap_cluster_hi,
    input wire logic strap_cluster_lo,
    input wire logic [3:1] arb_req_peer_pins,
    input wire logic addr_bit20_mask_n,
    input wire logic ignore_fpu_err_n,
    input wire logic [1:0] local_irq_pins,
    input wire logic tgt_err_seen,
    input wire logic sw_policy_wr,
    input wire policy_type sw_policy_wdata,
    output hw_cfg_type hw_cfg,
    output policy_type policy,
    output logic cfg_valid,
    output logic in_reset,
    output logic ratio_sampling,
    output logic bist_start,
    output logic bus_err_n_tgt_drive,
    output logic machine_check_req
);

    // Parameters the capture logic cannot serve: depths must fit the
    // four-bit field and shallow must stay below deep
    if ((IOQ_SHALLOW < 1) || (IOQ_DEEP <= IOQ_SHALLOW) ||
        (IOQ_DEEP >= (1 << `IOQ_DEPTH_W)))
    begin : g_bad_ioq
        $error("reset_strap_config_latch: IOQ depths out of range");
    end

    localparam int unsigned PIN_W = $bits(pin_bundle_type);

    // All module state in one record
    typedef struct packed {
        cfg_state_type state;
        logic sys_rst_prev;
        hw_cfg_type hw;
        policy_type policy;
        logic cfg_valid;
        logic in_reset;
        logic ratio_sampling;
        logic bist_start;
        logic bus_err_n_tgt_drive;
        logic machine_check_req;
    } latch_state_type;

    // Registered record and its next value
    latch_state_type q_r;
    latch_state_type q_nxt;

    // Pin levels before and after the synchroniser
    pin_bundle_type pins_raw;
    pin_bundle_type pins_s;
    logic [PIN_W-1:0] pins_s_bits;
    logic release_seen;

    // Cluster ID from electrical levels of the two straps
    function automatic logic [1:0] decode_cluster(input logic hi, input logic lo);
        logic [1:0] id;
        id = {~hi, ~lo}; // (R16)
        return id;
    endfunction : decode_cluster

    // Agent ID from the peer request pins; one low pin expected
    // Several low pins point to a wiring fault; the highest pin then wins
    function automatic logic [1:0] decode_agent(input logic [2:0] peer);
        logic [1:0] id;
        id = `ID_0;
        if (!peer[2])
        begin
            id = `ID_1; // (R18)
        end
        else if (!peer[1])
        begin
            id = `ID_2; // (R18)
        end
        else if (!peer[0])
        begin
            id = `ID_3; // (R18)
        end
        return id;
    endfunction : decode_agent

    // Arbitration ID: checkers borrow the ID of their master
    // Masters and lone agents keep their own ID
    function automatic logic [1:0] decode_arb(input logic [1:0] agent, input logic lockstep);
        logic [1:0] id;
        id = agent; // (R18)
        if (lockstep && (agent == `ID_1))
        begin
            id = `ID_0; // (R19)
        end
        else if (lockstep && (agent == `ID_3))
        begin
            id = `ID_2; // (R19)
        end
        return id;
    endfunction : decode_arb

    // Checker role follows odd agent IDs under lockstep
    function automatic logic is_checker(input logic [1:0] agent, input logic lockstep);
        logic chk;
        chk = lockstep && ((agent == `ID_1) || (agent == `ID_3)); // (R19)
        return chk;
    endfunction : is_checker

    // Whole hardware configuration from one sampled pin set
    function automatic hw_cfg_type capture(input pin_bundle_type p);
        hw_cfg_type c;
        logic [1:0] agent;
        logic lockstep;
        lockstep = ~p.strap_frc; // (R15)
        agent = decode_agent(p.peer_pins); // (R17)
        c.outputs_float = ~p.cache_flush_n; // (R1)
        c.addr_err_obs_en = ~p.strap_addr_err_obs; // (R6)
        c.bus_err_obs_en = 1'b0; // (R10)
        c.bus_init_obs_en = ~p.strap_bus_init_obs; // (R12)
        c.ioq_depth = p.strap_ioq_shallow ? `IOQ_DEPTH_W'(IOQ_DEEP)
                                          : `IOQ_DEPTH_W'(IOQ_SHALLOW); // (R13)
        c.reset_vector = p.strap_low_vector ? `VEC_HIGH : `VEC_LOW; // (R14)
        c.lockstep_en = lockstep; // (R15)
        c.lockstep_checker = is_checker(agent, lockstep);
        c.cluster_id = decode_cluster(p.strap_cluster_hi, p.strap_cluster_lo);
        c.agent_id = agent;
        c.arb_id = decode_arb(agent, lockstep);
        // Ratio pins stay raw; decoding them is left to the clock logic
        c.ratio_raw = {p.local_irq_pins, p.ignore_fpu_err_n, p.addr_bit20_mask_n}; // (R22)
        return c;
    endfunction : capture

    // Values shown before any capture has happened
    // Deep queue and high vector match an agent with no straps pulled low
    function automatic hw_cfg_type hw_default();
        hw_cfg_type c;
        c.outputs_float = 1'b0;
        c.addr_err_obs_en = 1'b0;
        c.bus_err_obs_en = 1'b0;
        c.bus_init_obs_en = 1'b0;
        c.ioq_depth = `IOQ_DEPTH_W'(IOQ_DEEP);
        c.reset_vector = `VEC_HIGH;
        c.lockstep_en = 1'b0;
        c.lockstep_checker = 1'b0;
        c.cluster_id = `ID_0;
        c.agent_id = `ID_0;
        c.arb_id = `ID_0;
        c.ratio_raw = `RATIO_RAW_RESET;
        return c;
    endfunction : hw_default

    // Group pins so that straps and reset share one pipeline
    // Field order follows pin_bundle_type
    always_comb
    begin
        pins_raw.sys_reset_n = sys_reset_n;
        pins_raw.cache_flush_n = cache_flush_n;
        pins_raw.soft_init_n = soft_init_n;
        pins_raw.strap_frc = strap_frc;
        pins_raw.strap_low_vector = strap_low_vector;
        pins_raw.strap_ioq_shallow = strap_ioq_shallow;
        pins_raw.strap_addr_err_obs = strap_addr_err_obs;
        pins_raw.strap_bus_err_obs = strap_bus_err_obs;
        pins_raw.strap_bus_init_obs = strap_bus_init_obs;
        pins_raw.strap_cluster_hi = strap_cluster_hi;
        pins_raw.strap_cluster_lo = strap_cluster_lo;
        pins_raw.peer_pins = arb_req_peer_pins;
        pins_raw.addr_bit20_mask_n = addr_bit20_mask_n;
        pins_raw.ignore_fpu_err_n = ignore_fpu_err_n;
        pins_raw.local_irq_pins = local_irq_pins;
    end

    // Same delay on reset and straps keeps the sample aligned to the pin edge,
    // relying on straps holding two clocks past release (R23)
    pin_sync #(
        .WIDTH(PIN_W)
    ) u_pin_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .pins_async(pins_raw),
        .pins_sync(pins_s_bits)
    );

    assign pins_s = pin_bundle_type'(pins_s_bits);

    // Rising edge of the synchronised system reset
    // Previous level resets high, so block reset alone gives no false edge
    assign release_seen = ~q_r.sys_rst_prev & pins_s.sys_reset_n;

    // Next-state logic
    always_comb
    begin
        q_nxt = q_r;
        q_nxt.sys_rst_prev = pins_s.sys_reset_n;
        q_nxt.bist_start = 1'b0;
        q_nxt.machine_check_req = 1'b0;
        // Target errors never reach the bus error pin, whatever the policy
        q_nxt.bus_err_n_tgt_drive = 1'b0; // (R8)

        // Any active system reset clears the software policies
        // A write in the same cycle is lost; software writes after release
        if (!pins_s.sys_reset_n)
        begin
            q_nxt.policy = policy_type'(`POLICY_RESET); // (R3) (R4) (R5) (R7) (R9) (R11) (R21)
        end

        // Powerup waits for a first reset pulse, then held and run alternate
        case (q_r.state)
            ST_POWERUP:
            begin
                // Nothing is valid until a full reset pulse has been seen
                if (!pins_s.sys_reset_n)
                begin
                    q_nxt.state = ST_HELD;
                    q_nxt.in_reset = 1'b1;
                    q_nxt.ratio_sampling = 1'b1; // (R22)
                end
            end
            ST_HELD:
            begin
                // Hardware fields keep their old values through reset
                // Writes are not taken here; the reset keeps policy clear
                if (release_seen)
                begin
                    q_nxt.hw = capture(pins_s); // (R24)
                    q_nxt.cfg_valid = 1'b1;
                    q_nxt.bist_start = ~pins_s.soft_init_n; // (R2)
                    q_nxt.in_reset = 1'b0;
                    q_nxt.ratio_sampling = 1'b0; // (R22)
                    q_nxt.state = ST_RUN;
                end
            end
            ST_RUN:
            begin
                // Reset entry; hardware fields hold until the next release
                if (!pins_s.sys_reset_n)
                begin
                    q_nxt.state = ST_HELD;
                    q_nxt.in_reset = 1'b1;
                    q_nxt.ratio_sampling = 1'b1; // (R22)
                end
                else
                begin
                    // Writes count only outside reset
                    if (sw_policy_wr)
                    begin
                        q_nxt.policy = sw_policy_wdata; // (R3) (R4) (R5) (R7) (R8) (R9) (R11) (R21)
                    end
                    // Target errors are observed even though never driven
                    q_nxt.machine_check_req = tgt_err_seen; // (R8)
                end
            end
            default:
            begin
                q_nxt.state = ST_POWERUP;
            end
        endcase
    end

    // State register
    // Block reset forgets any capture; a new system reset pulse is needed
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            q_r.state <= ST_POWERUP;
            q_r.sys_rst_prev <= `PIN_SYNC_RESET;
            q_r.hw <= hw_default();
            q_r.policy <= policy_type'(`POLICY_RESET);
            q_r.cfg_valid <= 1'b0;
            q_r.in_reset <= 1'b0;
            q_r.ratio_sampling <= 1'b0;
            q_r.bist_start <= 1'b0;
            q_r.bus_err_n_tgt_drive <= 1'b0;
            q_r.machine_check_req <= 1'b0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // Every output straight from the state record
    // No logic after the flops, so consumers see no glitches
    assign hw_cfg = q_r.hw; // (R25)
    assign policy = q_r.policy; // (R25)
    assign cfg_valid = q_r.cfg_valid;
    assign in_reset = q_r.in_reset;
    assign ratio_sampling = q_r.ratio_sampling;
    assign bist_start = q_r.bist_start;
    assign bus_err_n_tgt_drive = q_r.bus_err_n_tgt_drive;
    assign machine_check_req = q_r.machine_check_req;

endmodule : reset_strap_config_latch

`default_nettype wire

/* reset_strap_config_latch_tb.sv */
// Purpose: Self-checking bench for the strap latch
// Assumes: Partner model drives all pins; policy and error strobes from here
// Notes: Each capture is judged after the straps have been inverted
`timescale 1ns/1ps
`default_nettype none

module reset_strap_config_latch_tb;
    import cfg_pkg::*;
    logic core_clk = 0;
    logic reset_n = 0;
    logic start = 0;
    logic tgt_err_seen = 0;
    logic sw_policy_wr = 0;
    policy_type sw_policy_wdata = '0;
    pin_bundle_type cfg = '1;
    pin_bundle_type pins;
    logic busy, cfg_valid, in_reset, ratio_sampling, bist_start;
    logic bus_err_n_tgt_drive, machine_check_req;
    hw_cfg_type hw_cfg;
    policy_type policy;
    int n_fail = 0;
    int n_checks = 0;
    int bist_cnt = 0;
    logic captured = 1'b0;

    always #5 core_clk = ~core_clk;

    strap_source src_u (.core_clk(core_clk), .start(start), .cfg_in(cfg), .pins(pins),
        .busy(busy));

    reset_strap_config_latch dut_u (
        .core_clk(core_clk), .reset_n(reset_n), .sys_reset_n(pins.sys_reset_n),
        .cache_flush_n(pins.cache_flush_n), .soft_init_n(pins.soft_init_n),
        .strap_frc(pins.strap_frc), .strap_low_vector(pins.strap_low_vector),
        .strap_ioq_shallow(pins.strap_ioq_shallow),
        .strap_addr_err_obs(pins.strap_addr_err_obs),
        .strap_bus_err_obs(pins.strap_bus_err_obs),
        .strap_bus_init_obs(pins.strap_bus_init_obs),
        .strap_cluster_hi(pins.strap_cluster_hi), .strap_cluster_lo(pins.strap_cluster_lo),
        .arb_req_peer_pins(pins.peer_pins), .addr_bit20_mask_n(pins.addr_bit20_mask_n),
        .ignore_fpu_err_n(pins.ignore_fpu_err_n), .local_irq_pins(pins.local_irq_pins),
        .tgt_err_seen(tgt_err_seen), .sw_policy_wr(sw_policy_wr),
        .sw_policy_wdata(sw_policy_wdata), .hw_cfg(hw_cfg), .policy(policy),
        .cfg_valid(cfg_valid), .in_reset(in_reset), .ratio_sampling(ratio_sampling),
        .bist_start(bist_start), .bus_err_n_tgt_drive(bus_err_n_tgt_drive),
        .machine_check_req(machine_check_req)
    );

    // Count self test pulses so a stretched pulse is caught too; cleared per reset
    always @(posedge core_clk)
    begin
        if (start)
            bist_cnt <= 0;
        else if (bist_start === 1'b1)
            bist_cnt <= bist_cnt + 1;
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude();
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // Expected configuration from the pin levels at release
    function automatic hw_cfg_type exp_cfg(input pin_bundle_type p);
        hw_cfg_type e;
        logic [1:0] ag;
        ag = !p.peer_pins[2] ? 2'h1 : !p.peer_pins[1] ? 2'h2 : !p.peer_pins[0] ? 2'h3 : 2'h0;
        e.outputs_float = !p.cache_flush_n;
        e.addr_err_obs_en = !p.strap_addr_err_obs;
        e.bus_err_obs_en = 1'b0;
        e.bus_init_obs_en = !p.strap_bus_init_obs;
        e.ioq_depth = p.strap_ioq_shallow ? 4'h8 : 4'h1;
        e.reset_vector = p.strap_low_vector ? 32'hFFFFFFF0 : 32'h000FFFF0;
        e.lockstep_en = !p.strap_frc;
        e.lockstep_checker = !p.strap_frc && ag[0];
        e.cluster_id = {!p.strap_cluster_hi, !p.strap_cluster_lo};
        e.agent_id = ag;
        e.arb_id = !p.strap_frc ? {ag[1], 1'b0} : ag;
        e.ratio_raw = {p.local_irq_pins, p.ignore_fpu_err_n, p.addr_bit20_mask_n};
        return e;
    endfunction : exp_cfg

    // Write policy bits; holding the strobe between calls gives back-to-back writes
    task automatic write_pol(input policy_type v);
        sw_policy_wr <= 1'b1;
        sw_policy_wdata <= v;
        @(posedge core_clk);
        #1 check("policy", policy, captured ? v : 8'h00);
    endtask : write_pol

    // One full reset with the given straps, after an all-ones policy write that only takes once a capture exists
    task automatic t_reset(input pin_bundle_type c);
        write_pol(8'hFF);
        sw_policy_wr <= 1'b0;
        cfg <= c;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1 check("ratio_sampling", ratio_sampling, 1'b1);
        check("policy_in_reset", policy, 8'h00);
        for (int i = 0; i < 40 && busy; i++) @(posedge core_clk);
        #1 check("hw_cfg", hw_cfg, exp_cfg(c));
        check("cfg_valid", cfg_valid, 1'b1);
        check("in_reset", in_reset, 1'b0);
        check("bist_count", bist_cnt, !c.soft_init_n);
        check("policy_after", policy, 8'h00);
        captured = 1'b1;
    endtask : t_reset

    // Target error: observed and reported, drive bit set but never driven
    task automatic t_target();
        write_pol(8'h40);
        sw_policy_wr <= 1'b0;
        tgt_err_seen <= 1'b1;
        @(posedge core_clk);
        tgt_err_seen <= 1'b0;
        #1 check("machine_check", machine_check_req, 1'b1);
        check("bus_err_n_tgt_drive", bus_err_n_tgt_drive, 1'b0);
        @(posedge core_clk);
        #1 check("machine_check_end", machine_check_req, 1'b0);
    endtask : t_target

    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        conclude();
    end

    initial
    begin
        pin_bundle_type c;
        logic [2:0] k;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 check("hw_cfg_reset", hw_cfg, {8'h08, 32'hFFFF_FFF0, 12'h00F});
        check("cfg_valid_reset", cfg_valid, 1'b0);
        check("in_reset_reset", in_reset, 1'b0);
        // All agent, lockstep and cluster codes; flush low first, then clean
        for (int i = 0; i < 8; i++)
        begin
            k = 3'(i);
            c = '1;
            c.cache_flush_n = (i != 0);
            c.soft_init_n = k[0];
            c.strap_ioq_shallow = k[0];
            c.strap_low_vector = k[1];
            c.strap_addr_err_obs = k[2];
            c.strap_bus_err_obs = k[2];
            c.strap_bus_init_obs = !k[2];
            c.strap_frc = k[2];
            {c.strap_cluster_hi, c.strap_cluster_lo} = k[1:0];
            c.peer_pins = (k[1:0] == 2'h0) ? 3'h7 : ~(3'h4 >> (k[1:0] - 2'h1));
            c.local_irq_pins = k[1:0];
            c.addr_bit20_mask_n = k[2];
            t_reset(c);
        end
        // Walking one through the policy bits, written back to back
        for (int i = 0; i < 8; i++)
            write_pol(policy_type'(8'h01 << i));
        sw_policy_wr <= 1'b0;
        @(posedge core_clk);
        t_target();
        conclude();
    end
endmodule : reset_strap_config_latch_tb

`default_nettype wire

/* strap_cfg_defs.svh */
// Purpose: Named constants for the reset strap configuration latch
// Assumes: Included by its bare name from design files
// Notes: Definitions only
`ifndef STRAP_CFG_DEFS_SVH
`define STRAP_CFG_DEFS_SVH

// In-order queue depths
`define IOQ_DEPTH_DEEP 8
`define IOQ_DEPTH_SHALLOW 1
`define IOQ_DEPTH_W 4

// Reset vectors: 1M-16 and 4G-16
`define VEC_LOW 32'h000F_FFF0
`define VEC_HIGH 32'hFFFF_FFF0

// Two-bit identifier encodings
`define ID_0 2'h0
`define ID_1 2'h1
`define ID_2 2'h2
`define ID_3 2'h3

// Reset values
`define POLICY_RESET 8'h00
`define RATIO_RAW_RESET 4'hF
`define PIN_SYNC_RESET 1'b1

`endif

/* strap_cfg_properties.sv */
// Purpose: Concurrent checks on the strap latch outputs
// Assumes: Single clock domain, synchronous active-low block reset
// Notes: Bound to the latch; sees only its ports
`timescale 1ns/1ps
`default_nettype none

module strap_cfg_properties
    import cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic tgt_err_seen,
    input wire logic sw_policy_wr,
    input wire policy_type sw_policy_wdata,
    input wire hw_cfg_type hw_cfg,
    input wire policy_type policy,
    input wire logic cfg_valid,
    input wire logic in_reset,
    input wire logic ratio_sampling,
    input wire logic bist_start,
    input wire logic bus_err_n_tgt_drive,
    input wire logic machine_check_req
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Request taken in run state and run state still held one cycle on
    sequence run_wr;
        sw_policy_wr && cfg_valid && !in_reset ##1 !in_reset;
    endsequence
    sequence run_tgt;
        tgt_err_seen && cfg_valid && !in_reset ##1 !in_reset;
    endsequence

    a_bist_one_pulse: assert property (bist_start |=> !bist_start)
        else $error("self test start longer than one cycle");
    a_bist_at_release: assert property (bist_start |-> $fell(in_reset))
        else $error("self test start away from reset release");
    a_policy_clear: assert property ($rose(in_reset) |-> policy == 8'h00)
        else $error("policy bits not cleared by reset");
    a_policy_write: assert property (run_wr |-> policy == $past(sw_policy_wdata))
        else $error("policy write not shown");
    a_tgt_no_drive: assert property (!bus_err_n_tgt_drive)
        else $error("target error drive asserted");
    a_mc_follows: assert property (run_tgt |-> machine_check_req)
        else $error("machine check missing after target error");
    a_mc_cause: assert property (machine_check_req |-> $past(tgt_err_seen))
        else $error("machine check without target error");
    a_bus_err_n_obs_off: assert property (!hw_cfg.bus_err_obs_en)
        else $error("bus error receiver enabled");
    a_cfg_hold: assert property (!$fell(in_reset) |-> $stable(hw_cfg))
        else $error("configuration changed outside capture");
    a_ratio_window: assert property (ratio_sampling == in_reset)
        else $error("ratio sampling not tied to reset");
    a_ioq_legal: assert property (cfg_valid |-> hw_cfg.ioq_depth inside {4'h1, 4'h8})
        else $error("queue depth neither one nor eight");
endmodule : strap_cfg_properties

bind reset_strap_config_latch strap_cfg_properties u_props (
    .core_clk(core_clk), .reset_n(reset_n), .tgt_err_seen(tgt_err_seen),
    .sw_policy_wr(sw_policy_wr), .sw_policy_wdata(sw_policy_wdata), .hw_cfg(hw_cfg),
    .policy(policy), .cfg_valid(cfg_valid), .in_reset(in_reset),
    .ratio_sampling(ratio_sampling), .bist_start(bist_start),
    .bus_err_n_tgt_drive(bus_err_n_tgt_drive), .machine_check_req(machine_check_req)
);

`default_nettype wire

/* strap_source.sv */
// Purpose: System reset logic model driving reset and straps
// Assumes: One start pulse begins one reset sequence
// Notes: Released straps show inverted levels, so late sampling shows up
`timescale 1ns/1ps
`default_nettype none

module strap_source
    import cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic start,
    input wire pin_bundle_type cfg_in,
    output pin_bundle_type pins,
    output logic busy
);
    int cnt = 0;

    // Sequence step: reset low 1..11, release at 12, straps held to 14
    always_ff @(posedge core_clk)
    begin
        if (start)
            cnt <= 1;
        else if (cnt != 0 && cnt < 20)
            cnt <= cnt + 1;
        else
            cnt <= 0;
    end

    // Straps and peer pins valid well ahead, dropped two clocks after release
    always_comb
    begin
        pins = (cnt >= 1 && cnt < 14) ? cfg_in : ~cfg_in;
        pins.sys_reset_n = !(cnt >= 1 && cnt < 12);
        busy = (cnt != 0);
    end
endmodule : strap_source

`default_nettype wire
